/* File: verilog/sbs_sram_port.sv */
/*
 * Synchronous pipelined burst memory port: command pipeline, burst address
 * counter, lane-masked self-timed writes through a queue, sleep control.
 * Assumes the controller runs on clk and drives its inputs from clk logic;
 * the sleep request and output enable are asynchronous and resynchronised.
 */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - All synchronous inputs are captured on the rising clock edge.
// - Read data leaves through output registers clocked on the rising edge.
// - Deasserted clock qualifier freezes pipeline and output state; the write queue drain and sleep control keep running.
// - Reads and writes follow back to back, one word per cycle, no waits.
// - Write strobe requests a write; per-lane selects decide which lanes store.
// - Accepted writes complete internally without controller timing.
// - Selected only with first and third selects low, second high.
// - Data outputs float during a write's data cycle.
// - Bursts follow linear or interleaved order per the order select input.
// - Sleep request and stopped clock both keep stored contents.
// - Array is 256K x 36 or 512K x 18, each lane nine bits with parity.

module sbs_sram_port #(
    parameter bit WIDE = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clock_qualifier_n,
    input wire logic [(WIDE ? 18 : 19)-1:0] address,
    input wire logic advance_or_load,
    input wire logic write_strobe_n,
    input wire logic chip_select_first_n,
    input wire logic chip_select_second,
    input wire logic chip_select_third_n,
    input wire logic lane_a_write_select_n,
    input wire logic lane_b_write_select_n,
    input wire logic lane_c_write_select_n,
    input wire logic lane_d_write_select_n,
    input wire logic burst_order_interleaved,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic [(WIDE ? 36 : 18)-1:0] dq_in,
    output logic [(WIDE ? 36 : 18)-1:0] dq_out,
    output logic dq_oe_n
);
    localparam int ADDR_W = WIDE ? sbs_pkg::WIDE_ADDR_W : sbs_pkg::NARROW_ADDR_W;
    localparam int LANES = WIDE ? sbs_pkg::WIDE_LANES : sbs_pkg::NARROW_LANES;
    localparam int DATA_W = LANES * sbs_pkg::LANE_W;
    localparam int AW_MAX = sbs_pkg::ADDR_W_MAX;
    localparam int DW_MAX = sbs_pkg::DATA_W_MAX;
    localparam int LN_MAX = sbs_pkg::LANES_MAX;

    if (DATA_W != $bits(dq_in) || ADDR_W != $bits(address)) begin : g_bad_org
        $error("sbs_sram_port port widths do not match the organisation");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Burst address: low two bits count from the loaded base

    function automatic logic [AW_MAX-1:0] burst_addr(input sbs_pkg::sbs_cmd_type c);
        logic [sbs_pkg::BURST_W-1:0] lo;
        lo = c.interleave ? (c.base[1:0] ^ c.count) : (c.base[1:0] + c.count);
        burst_addr = {c.base[AW_MAX-1:2], lo};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    sbs_pkg::sbs_cmd_type s1;
    sbs_pkg::sbs_cmd_type s2;
    sbs_pkg::sbs_cmd_type s3;
    sbs_pkg::sbs_cmd_type next_s1;
    sbs_pkg::sbs_sleep_type slp_state;
    sbs_pkg::sbs_sleep_type next_slp_state;
    sbs_pkg::sbs_wr_type wq_in;
    sbs_pkg::sbs_wr_type wq_out;
    logic run;
    logic awake;
    logic selected;
    logic pipe_idle;
    logic slp_meta;
    logic slp_sync;
    logic oe_meta;
    logic oe_sync;
    logic wq_push;
    logic wq_in_ready;
    logic wq_out_valid;
    logic wq_out_ready;
    logic drain_fire;
    logic [LN_MAX-1:0] lane_sel;
    logic [AW_MAX-1:0] s1_addr;
    logic [AW_MAX-1:0] s3_addr;
    logic [DATA_W-1:0] array_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Asynchronous pins pass two flip-flops

    always_ff @(posedge clk) begin
        slp_meta <= sleep_request;
        slp_sync <= slp_meta;
    end

    always_ff @(posedge clk) begin
        oe_meta <= output_enable_n;
        oe_sync <= oe_meta;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Qualified clock: a full write queue also stalls, so nothing is dropped

    assign run = ~clock_qualifier_n & wq_in_ready;
    assign awake = (slp_state == sbs_pkg::sbs_awake);
    assign selected = ~chip_select_first_n & chip_select_second & ~chip_select_third_n;
    assign lane_sel = {~lane_d_write_select_n, ~lane_c_write_select_n,
                       ~lane_b_write_select_n, ~lane_a_write_select_n};
    assign s1_addr = burst_addr(s1);
    assign s3_addr = burst_addr(s3);
    assign pipe_idle = ~s1.valid & ~s2.valid & ~s3.valid;

    ////////////////////////////////////////////////////////////////////////////
    // Command input stage

    always_comb begin
        next_s1 = s1;
        if (!advance_or_load) begin
            next_s1.valid = selected & awake;
            next_s1.write = ~write_strobe_n;
            next_s1.interleave = burst_order_interleaved;
            next_s1.base = AW_MAX'(address);
            next_s1.count = '0;
        end else begin
            next_s1.valid = s1.valid & awake;
            next_s1.count = s1.count + 2'h1;
        end
        // Narrow organisation has only lanes a and b
        next_s1.lanes = lane_sel & LN_MAX'((1 << LANES) - 1);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1 <= '0;
        end else if (run) begin
            s1 <= next_s1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s2 <= '0;
            s3 <= '0;
        end else if (run) begin
            s2 <= s1;
            s3 <= s2;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Storage and read path

    sbs_lane_array #(
        .ADDR_W(ADDR_W),
        .LANES(LANES),
        .LANE_W(sbs_pkg::LANE_W)
    ) u_array (
        .clk(clk),
        .rst_n(rst_n),
        .rd_en(run & s1.valid & ~s1.write),
        .rd_addr(s1_addr[ADDR_W-1:0]),
        .rd_data(array_rdata),
        .wr_en(drain_fire),
        .wr_addr(wq_out.addr[ADDR_W-1:0]),
        .wr_lanes(wq_out.lanes[LANES-1:0]),
        .wr_data(wq_out.data[DATA_W-1:0])
    );

    // Output enable passes two sync flops and this register, so it acts three edges late rather than at once
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dq_oe_n <= 1'b1;
        end else if (run) begin
            dq_oe_n <= ~(s2.valid & ~s2.write & ~oe_sync);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dq_out <= '0;
        end else if (run && s2.valid && !s2.write) begin
            dq_out <= array_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write path: data taken in the data cycle, landed by the queue drain

    assign wq_push = run & s3.valid & s3.write;

    always_comb begin
        wq_in.addr = s3_addr;
        wq_in.lanes = s3.lanes;
        wq_in.data = DW_MAX'(dq_in);
    end

    // A read of a word still queued sees its old contents
    sbs_fifo #(
        .WIDTH($bits(sbs_pkg::sbs_wr_type)),
        .DEPTH(sbs_pkg::WQ_DEPTH)
    ) u_write_queue (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(wq_push),
        .in_ready(wq_in_ready),
        .in_data(wq_in),
        .out_valid(wq_out_valid),
        .out_ready(wq_out_ready),
        .out_data(wq_out)
    );

    // Drain runs on the raw clock, independent of the qualifier
    assign wq_out_ready = (slp_state != sbs_pkg::sbs_asleep);
    assign drain_fire = wq_out_valid & wq_out_ready;

    ////////////////////////////////////////////////////////////////////////////
    // Sleep control: refuse new work, finish in-flight, then park

    always_comb begin
        next_slp_state = slp_state;
        case (slp_state)
            sbs_pkg::sbs_awake: begin
                if (slp_sync) begin
                    next_slp_state = sbs_pkg::sbs_entering;
                end
            end
            sbs_pkg::sbs_entering: begin
                if (!slp_sync) begin
                    next_slp_state = sbs_pkg::sbs_awake;
                end else if (pipe_idle && !wq_out_valid) begin
                    next_slp_state = sbs_pkg::sbs_asleep;
                end
            end
            sbs_pkg::sbs_asleep: begin
                if (!slp_sync) begin
                    next_slp_state = sbs_pkg::sbs_waking;
                end
            end
            sbs_pkg::sbs_waking: begin
                next_slp_state = sbs_pkg::sbs_awake;
            end
            default: begin
                next_slp_state = sbs_pkg::sbs_awake;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            slp_state <= sbs_pkg::sbs_awake;
        end else begin
            slp_state <= next_slp_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence read_taken;
        run && !advance_or_load && selected && awake && write_strobe_n;
    endsequence

    sequence write_taken;
        run && !advance_or_load && selected && awake && !write_strobe_n;
    endsequence

    input_capture_a: assert property (run && !advance_or_load |=>
        s1.base[ADDR_W-1:0] == $past(address) && s1.write == !$past(write_strobe_n))
        else $error("command not captured");

    read_data_a: assert property (run && s2.valid && !s2.write |=>
        dq_out == $past(array_rdata))
        else $error("read data not registered");

    stall_hold_a: assert property (!run |=>
        $stable(s1) && $stable(s2) && $stable(dq_out) && $stable(dq_oe_n))
        else $error("state moved while stalled");

    no_wait_state_a: assert property (slp_state == sbs_pkg::sbs_awake |->
        wq_in_ready)
        else $error("stall inserted while awake");

    chip_select_a: assert property (run && !advance_or_load && !selected |=>
        !s1.valid)
        else $error("deselected command accepted");

    write_float_a: assert property (write_taken ##1 run ##1 run |=> dq_oe_n)
        else $error("outputs driven in write data cycle");

    linear_burst_a: assert property (run && advance_or_load && !s1.interleave |=>
        s1_addr[1:0] == $past(s1_addr[1:0]) + 2'h1)
        else $error("linear burst step wrong");

    interleave_burst_a: assert property (run && advance_or_load && s1.interleave
        && s1.count == 2'h0 |=> s1_addr[1:0] == ($past(s1.base[1:0]) ^ 2'h1))
        else $error("interleaved burst step wrong");

    sleep_idle_a: assert property (slp_state == sbs_pkg::sbs_asleep |->
        pipe_idle && !drain_fire)
        else $error("activity while asleep");

    read_latency_a: assert property (read_taken ##1 run ##1 run |=>
        dq_oe_n == $past(oe_sync))
        else $error("read data not on bus two cycles on");

    burst_advance_a: assert property (run && advance_or_load |=>
        s1.base == $past(s1.base) && s1.count == $past(s1.count) + 2'h1)
        else $error("burst counter did not advance");

endmodule

`default_nettype wire

/* File: pkg/sbs_pkg.sv */
/*
 * Shared constants and carrier types for the burst memory port.
 * Assumes nothing of its surroundings; imported by scope only.
 */
package sbs_pkg;

    // Organisations: wide is 256K x 36, narrow is 512K x 18
    localparam int WIDE_ADDR_W = 18;
    localparam int NARROW_ADDR_W = 19;
    localparam int WIDE_LANES = 4;
    localparam int NARROW_LANES = 2;
    localparam int LANE_W = 9;
    localparam int ADDR_W_MAX = 19;
    localparam int LANES_MAX = 4;
    localparam int DATA_W_MAX = 36;

    // Burst counter width and write queue depth
    localparam int BURST_W = 2;
    localparam int WQ_DEPTH = 32;

    typedef enum logic [1:0] {
        sbs_awake = 2'b00,
        sbs_entering = 2'b01,
        sbs_asleep = 2'b11,
        sbs_waking = 2'b10
    } sbs_sleep_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic interleave;
        logic [ADDR_W_MAX-1:0] base;
        logic [BURST_W-1:0] count;
        logic [LANES_MAX-1:0] lanes;
    } sbs_cmd_type;

    typedef struct packed {
        logic [ADDR_W_MAX-1:0] addr;
        logic [LANES_MAX-1:0] lanes;
        logic [DATA_W_MAX-1:0] data;
    } sbs_wr_type;

endpackage

/* File: verilog/sbs_fifo.sv */
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module sbs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("sbs_fifo depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != CW'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + PW'(1);
            end
            if (pop) begin
                rd_ptr <= rd_ptr + PW'(1);
            end
            count <= count + CW'(push) - CW'(pop);
        end
    end

endmodule

`default_nettype wire

/* File: verilog/sbs_lane_array.sv */
/*
 * Storage array with one registered read port and one lane-masked write port.
 * Assumes the caller keeps both addresses in range; the array has no reset.
 */
`timescale 1ns/1ps
`default_nettype none

module sbs_lane_array #(
    parameter int ADDR_W = 18,
    parameter int LANES = 4,
    parameter int LANE_W = 9
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rd_en,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [LANES*LANE_W-1:0] rd_data,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [LANES-1:0] wr_lanes,
    input wire logic [LANES*LANE_W-1:0] wr_data
);
    logic [LANES*LANE_W-1:0] mem [2**ADDR_W];

    always_ff @(posedge clk) begin
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end

    // Contents survive sleep and a stopped clock: nothing here ever clears them
    always_ff @(posedge clk) begin
        for (int i = 0; i < LANES; i++) begin
            if (wr_en && wr_lanes[i]) begin
                mem[wr_addr][i*LANE_W +: LANE_W] <= wr_data[i*LANE_W +: LANE_W];
            end
        end
    end

    lane_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en && wr_lanes[0] |=>
        mem[$past(wr_addr)][LANE_W-1:0] == $past(wr_data[LANE_W-1:0]))
        else $error("selected lane not written");

    lane_mask_a: assert property (@(posedge clk) disable iff (!rst_n)
        wr_en && !wr_lanes[0] |=>
        mem[$past(wr_addr)][LANE_W-1:0] == $past(mem[wr_addr][LANE_W-1:0]))
        else $error("unselected lane changed");

endmodule

`default_nettype wire

/* File: sim/sbs_ctrl_model.sv */
/*
 * Controller-side model: supplies write data in the data cycle and resolves the dq wire.
 * Assumes the bench flags each taken write beat before the edge that takes it.
 */
`timescale 1ns/1ps
`default_nettype none

module sbs_ctrl_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clock_qualifier_n,
    input wire logic beat_wr,
    input wire logic [35:0] beat_data,
    input wire logic [35:0] dq_out,
    input wire logic dq_oe_n,
    output logic [35:0] dq_in,
    output logic clash
);
    logic [2:0] wr_pipe;
    logic [35:0] wd [3];
    logic [35:0] last;

    ////////////////////////////////////////////////////////////////////////////////
    // Stalled edges stretch the data cycle as well
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_pipe <= 3'h0;
        end else if (!clock_qualifier_n) begin
            wr_pipe <= {wr_pipe[1:0], beat_wr};
            wd[0] <= beat_data;
            wd[1] <= wd[0];
            wd[2] <= wd[1];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clash <= 1'b0;
        end else if (wr_pipe[2] && !dq_oe_n) begin
            clash <= 1'b1;
        end
    end

    // Undriven wire moves every cycle so a stale value never passes
    always_ff @(posedge clk) begin
        last <= rst_n ? dq_in : 36'h0;
    end

    assign dq_in = wr_pipe[2] ? wd[2] : (!dq_oe_n ? dq_out : ~last);
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
/*
 * Self-checking bench for the burst memory port, wide organisation.
 * Assumes the controller model above; the bench keeps a queue-free pipeline model.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, sn) begin comparisons++; if ((sn) !== (ex)) begin err_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, ex, sn); end end

module testbench;
    logic clk, rst_n, clock_qualifier_n, advance_or_load, write_strobe_n;
    logic chip_select_first_n, chip_select_second, chip_select_third_n;
    logic burst_order_interleaved, output_enable_n, sleep_request;
    logic [3:0] lane_n;
    logic [17:0] address, b_base;
    logic [35:0] dq_in, dq_out, beat_data, r, d;
    logic dq_oe_n, beat_wr, clash, awake, oe_on, order_il, b_ok, b_wr, b_il;
    logic [1:0] b_n;
    logic [15:0] lfsr_state;
    logic p_rd [3];
    logic p_kn [3];
    logic [35:0] p_d [3];
    logic [35:0] mem [int];
    int wr_at [int];
    int err_count, comparisons, beat;

    sbs_sram_port #(.WIDE(1'b1)) u_dut (.clk(clk), .rst_n(rst_n),
        .clock_qualifier_n(clock_qualifier_n), .address(address),
        .advance_or_load(advance_or_load), .write_strobe_n(write_strobe_n),
        .chip_select_first_n(chip_select_first_n), .chip_select_second(chip_select_second),
        .chip_select_third_n(chip_select_third_n), .lane_a_write_select_n(lane_n[0]),
        .lane_b_write_select_n(lane_n[1]), .lane_c_write_select_n(lane_n[2]),
        .lane_d_write_select_n(lane_n[3]), .burst_order_interleaved(burst_order_interleaved),
        .output_enable_n(output_enable_n), .sleep_request(sleep_request),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n));

    sbs_ctrl_model u_ctrl (.clk(clk), .rst_n(rst_n), .clock_qualifier_n(clock_qualifier_n),
        .beat_wr(beat_wr), .beat_data(beat_data), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
        .dq_in(dq_in), .clash(clash));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] rnd();
        lfsr_state = {lfsr_state[14:0], lfsr_state[15] ^ lfsr_state[13] ^ lfsr_state[12]
            ^ lfsr_state[10]};
        return lfsr_state;
    endfunction

    function automatic logic [35:0] rnd36();
        logic [15:0] a, b, c;
        a = rnd();
        b = rnd();
        c = rnd();
        return {a[3:0], b, c};
    endfunction

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check();
        `CHK("clash", 1'b0, clash)
        `CHK("dq_oe_n", !(p_rd[2] && oe_on), dq_oe_n)
        if (p_rd[2] && oe_on && p_kn[2] && !$isunknown(p_d[2]))
            `CHK("dq_out", p_d[2], dq_out)
    endtask

    // One bus cycle; outputs of the previous edge are judged first
    task automatic cyc(input logic st, input logic ld, input logic wr, input logic [2:0] sel,
            input logic [17:0] a, input logic [3:0] ln, input logic [35:0] dv);
        logic [17:0] ad;
        logic [35:0] m;
        int k;
        @(negedge clk);
        check();
        clock_qualifier_n = st;
        advance_or_load = !ld;
        write_strobe_n = !wr;
        {chip_select_first_n, chip_select_second, chip_select_third_n} = sel;
        address = a;
        lane_n = ln;
        burst_order_interleaved = order_il;
        beat_data = dv;
        if (!st) begin
            if (ld) begin
                b_ok = (sel == 3'b010) && awake;
                b_wr = wr;
                b_base = a;
                b_il = order_il;
                b_n = 2'h0;
            end else begin
                b_n = b_n + 2'h1;
                b_ok = b_ok && awake;
            end
            ad = {b_base[17:2], b_il ? b_base[1:0] ^ b_n : b_base[1:0] + b_n};
            k = int'(ad);
            m = mem.exists(k) ? mem[k] : 36'hX;
            for (int i = 2; i > 0; i--) begin
                p_rd[i] = p_rd[i-1];
                p_kn[i] = p_kn[i-1];
                p_d[i] = p_d[i-1];
            end
            p_rd[0] = b_ok && !b_wr;
            // A read right behind a write of the same word may see old data
            p_kn[0] = !wr_at.exists(k) || (beat - wr_at[k] > 6);
            p_d[0] = m;
            if (b_ok && b_wr) begin
                for (int i = 0; i < 4; i++) if (!ln[i]) m[i*9+:9] = dv[i*9+:9];
                mem[k] = m;
                wr_at[k] = beat;
            end
            beat++;
        end
        beat_wr = !st && b_ok && b_wr;
        @(posedge clk);
    endtask

    task automatic idle(input int n);
        repeat (n) cyc(1'b0, 1'b1, 1'b0, 3'b110, 18'h0, 4'hF, 36'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        #40000;
        err_count++;
        give_verdict();
    end

    initial begin
        {rst_n, clock_qualifier_n, advance_or_load, write_strobe_n} = 4'h1;
        {chip_select_first_n, chip_select_second, chip_select_third_n} = 3'b110;
        {burst_order_interleaved, output_enable_n, sleep_request, order_il} = 4'h0;
        {lane_n, address, beat_data, beat_wr} = '0;
        {awake, oe_on, b_ok, b_wr, b_il, b_n, b_base} = {5'h18, 20'h0};
        lfsr_state = 16'hC91B;
        for (int i = 0; i < 3; i++) {p_rd[i], p_kn[i], p_d[i]} = '0;
        repeat (10) @(posedge clk);
        @(negedge clk);
        `CHK("reset dq_oe_n", 1'b1, dq_oe_n)
        `CHK("reset dq_out", 36'h0, dq_out)
        rst_n = 1'b1;
        idle(4);
        for (int i = 0; i < 16; i++) cyc(1'b0, 1'b1, 1'b1, 3'b010, 18'(i), 4'h0, rnd36());
        // Let the fill land before anything reads it back
        idle(8);
        $display("test fill done");
        repeat (300) begin
            r = rnd36();
            d = rnd36();
            order_il = r[19];
            cyc(r[1:0] == 2'h0, r[17] | r[18], r[2], r[5:3] == 3'h0 ? r[8:6] : 3'b010,
                18'(r[12:9]), r[16:13], d);
        end
        idle(8);
        $display("test random mix done");
        for (int il = 0; il < 2; il++) begin
            order_il = il[0];
            for (int n = 0; n < 4; n++) cyc(1'b0, n == 0, 1'b1, 3'b010, 18'h21, 4'h0, rnd36());
            idle(8);
            order_il = !il[0];
            for (int n = 0; n < 4; n++) cyc(1'b0, n == 0, 1'b0, 3'b010, 18'h21, 4'hF, 36'h0);
            idle(4);
        end
        $display("test bursts done");
        @(negedge clk) output_enable_n = 1'b1;
        idle(6);
        oe_on = 1'b0;
        for (int i = 0; i < 4; i++) cyc(1'b0, 1'b1, 1'b0, 3'b010, 18'(i), 4'hF, 36'h0);
        idle(4);
        @(negedge clk) output_enable_n = 1'b0;
        idle(6);
        oe_on = 1'b1;
        $display("test output enable done");
        @(negedge clk) sleep_request = 1'b1;
        idle(16);
        awake = 1'b0;
        cyc(1'b0, 1'b1, 1'b1, 3'b010, 18'h1, 4'h0, rnd36());
        for (int i = 0; i < 4; i++) cyc(1'b0, 1'b1, 1'b0, 3'b010, 18'(i), 4'hF, 36'h0);
        idle(4);
        @(negedge clk) sleep_request = 1'b0;
        idle(16);
        awake = 1'b1;
        for (int i = 0; i < 4; i++) cyc(1'b0, 1'b1, 1'b0, 3'b010, 18'(i), 4'hF, 36'h0);
        idle(6);
        $display("test sleep done");
        give_verdict();
    end
endmodule

`undef CHK
`default_nettype wire
